//--- spu_pkg.sv
// package: register map, field positions, reset values, timing and state codes
package spu_pkg;
  // register byte addresses
  localparam logic [4:0] SPU_ADDR_CONTROL = 5'h00;
  localparam logic [4:0] SPU_ADDR_BUFFER = 5'h04;
  localparam logic [4:0] SPU_ADDR_RATE = 5'h08;
  localparam logic [4:0] SPU_ADDR_POWER = 5'h0c;
  localparam logic [4:0] SPU_ADDR_RELOAD = 5'h10;
  // serial_control fields
  localparam int SPU_CTL_RX_DONE = 0;
  localparam int SPU_CTL_TX_DONE = 1;
  localparam int SPU_CTL_RX_NINTH = 2;
  localparam int SPU_CTL_TX_NINTH = 3;
  localparam int SPU_CTL_RX_EN = 4;
  localparam int SPU_CTL_FAULT = 5;
  localparam int SPU_CTL_MODE_LO = 6;
  localparam int SPU_CTL_MODE_HI = 7;
  // rate_gen_control fields
  localparam int SPU_RATE_SYNC_SRC = 0;
  localparam int SPU_RATE_BYPASS = 1;
  localparam int SPU_RATE_RX_SEL = 2;
  localparam int SPU_RATE_TX_SEL = 3;
  localparam int SPU_RATE_RUN = 4;
  // power_control fields
  localparam int SPU_PWR_FULL_SPEED = 0;
  localparam int SPU_PWR_FRAME_CHECK = 6;
  localparam int SPU_PWR_DOUBLER = 7;
  // reset values
  localparam logic [7:0] SPU_CTL_RESET = 8'h00;
  localparam logic [7:0] SPU_RATE_RESET = 8'h00;
  localparam logic [7:0] SPU_PWR_RESET = 8'h00;
  localparam logic [7:0] SPU_RELOAD_RESET = 8'h00;
  localparam logic [7:0] SPU_BUF_RESET = 8'h00;
  // timing counts
  localparam logic [2:0] SPU_PRESCALE_DIV = 3'h6;
  localparam logic [3:0] SPU_SYNC_FIXED_DIV = 4'h6;
  localparam logic [3:0] SPU_OVS = 4'hf;
  localparam logic [3:0] SPU_OVS_MID = 4'h7;
  localparam logic [3:0] SPU_SYNC_BITS = 4'h8;
  localparam logic [3:0] SPU_FRAME_MODE1 = 4'ha;
  localparam logic [3:0] SPU_FRAME_MODE23 = 4'hb;
  // states, one-hot
  typedef enum logic [2:0] {
    SPU_TX_IDLE = 3'b001,
    SPU_TX_ASYNC = 3'b010,
    SPU_TX_SYNC = 3'b100
  } spu_tx_e;
  typedef enum logic [1:0] {
    SPU_RX_IDLE = 2'b01,
    SPU_RX_BUSY = 2'b10
  } spu_rx_e;
endpackage : spu_pkg

//--- spu_rate_gen.sv
// internal reload baud generator: prescaler and 8-bit auto-reload counter
`timescale 1ns/1ps
module spu_rate_gen
  import spu_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control
  input wire logic i_per_tick,
  input wire logic i_run,
  input wire logic i_bypass,
  input wire logic [7:0] i_reload,
  // overflow pulse
  output logic o_ovf
);
  logic [2:0] pre;
  logic [7:0] cnt;
  wire pre_hit = i_bypass | (pre == SPU_PRESCALE_DIV - 3'h1);
  wire step = i_run & i_per_tick & pre_hit;
  wire wrap = (cnt == 8'hff);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pre <= 3'h0;
      cnt <= SPU_RELOAD_RESET;
      o_ovf <= 1'b0;
    end else begin
      o_ovf <= step & wrap; // R22
      if (i_run & i_per_tick) begin
        pre <= pre_hit ? 3'h0 : pre + 3'h1; // R22
      end
      if (step) begin
        cnt <= wrap ? i_reload : cnt + 8'h01; // R22
      end
    end
  end

  property p_gen_hold;
    @(posedge i_clock) disable iff (i_rst) !i_run |=> $stable(cnt) && !o_ovf;
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("generator moved while stopped"); // R22
endmodule : spu_rate_gen

//--- spu_serial_port.sv
// serial port: synchronous shift mode and three asynchronous modes on Avalon-MM
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// R1 - mode 0 half-duplex, eight clocks per byte
// R2 - mode 0 shifts eight bits, lsb first
// R3 - buffer write in mode 0 starts transmit
// R4 - each shift clock is high then low
// R5 - after bit 7 drive data high, tx_done
// R6 - software starts mode 0 receive via control
// R7 - mode 0 receive samples eight bits, rx_done
// R8 - mode 0 rate: clock/6 or generator
// R9 - generator rate formula with doubler, bypass
// R10 - mode 1 ten-bit frame, stop to ninth
// R11 - modes 2/3 eleven-bit frame with ninth bit
// R12 - two select bits choose the mode
// R13 - buffer write starts async transmit
// R14 - receive starts on falling input edge
// R15 - frame check flags bad stop bit
// R16 - stop_bit_fault sticky until software write
// R17 - frame check moves rx_done to stop
// R18 - modes 1/3 pick rx, tx rate sources
// R19 - mode 2 rate clock/32 or clock/16
// R20 - software loads reload value for baud
// R21 - peripheral clock halved in half-speed mode
// R22 - generator: reload timer, prescale, run bit
// R23 - software clears done flags itself
// R24 - async line idles high, start low
// R25 - async receive samples mid-bit, sixteen ticks
module spu_serial_port
  import spu_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // external timer overflow, same clock
  input wire logic i_t1_ovf,
  // serial pins
  input wire logic i_io_in,
  output logic o_io_out,
  output logic o_io_oe_n,
  output logic o_out_pin
);
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic [7:0] rate_ctl;
  logic [7:0] pwr_ctl;
  logic [7:0] reload;
  logic [7:0] rx_buf;
  logic io_m;
  logic io_s;
  logic io_d;
  logic per_half;
  logic h_per;
  logic h_int;
  logic h_t1;
  logic ovf_int;
  spu_tx_e tx_st;
  spu_rx_e rx_st;
  logic [9:0] tsh;
  logic [3:0] tbit;
  logic [3:0] tcnt;
  logic sy_rx;
  logic sy_ph;
  logic [8:0] rsh;
  logic [3:0] rbit;
  logic [3:0] rcnt;

  function automatic logic halve(input logic ev, input logic dbl, input logic h);
    return ev & (dbl | h);
  endfunction : halve

  // mode decode
  wire mode0 = ~ctl[SPU_CTL_MODE_HI] & ~ctl[SPU_CTL_MODE_LO]; // R12
  wire mode1 = ~ctl[SPU_CTL_MODE_HI] & ctl[SPU_CTL_MODE_LO]; // R12
  wire mode2 = ctl[SPU_CTL_MODE_HI] & ~ctl[SPU_CTL_MODE_LO]; // R12
  wire smod = pwr_ctl[SPU_PWR_DOUBLER];
  wire fce = pwr_ctl[SPU_PWR_FRAME_CHECK];

  // bus decode
  wire req = i_read | i_write;
  wire take = req & ~o_waitrequest;
  wire wr_ctl = i_write & take & (i_address == SPU_ADDR_CONTROL);
  wire wr_buf = i_write & take & (i_address == SPU_ADDR_BUFFER);
  wire wr_rate = i_write & take & (i_address == SPU_ADDR_RATE);
  wire wr_pwr = i_write & take & (i_address == SPU_ADDR_POWER);
  wire wr_reload = i_write & take & (i_address == SPU_ADDR_RELOAD);
  wire [31:0] rd_mux =
    (i_address == SPU_ADDR_CONTROL) ? {24'h000000, ctl} :
    (i_address == SPU_ADDR_BUFFER) ? {24'h000000, rx_buf} :
    (i_address == SPU_ADDR_RATE) ? {24'h000000, rate_ctl} :
    (i_address == SPU_ADDR_POWER) ? {24'h000000, pwr_ctl} :
    (i_address == SPU_ADDR_RELOAD) ? {24'h000000, reload} : 32'h00000000;

  // peripheral tick: every clock at full speed, every second clock otherwise
  wire per_tick = pwr_ctl[SPU_PWR_FULL_SPEED] | per_half; // R21
  wire tick_int = halve(ovf_int, smod, h_int); // R9
  wire tick_t1 = halve(i_t1_ovf, smod, h_t1);
  wire m2_tick = halve(per_tick, smod, h_per); // R19
  wire tx_tick = mode2 ? m2_tick : (rate_ctl[SPU_RATE_TX_SEL] ? tick_int : tick_t1); // R18
  wire rx_tick = mode2 ? m2_tick : (rate_ctl[SPU_RATE_RX_SEL] ? tick_int : tick_t1); // R18

  // mode 0 half-bit timing: three peripheral ticks fixed, eight generator ticks variable
  wire sy_var = rate_ctl[SPU_RATE_SYNC_SRC];
  wire sy_src = sy_var ? tick_int : per_tick; // R8
  wire [3:0] sy_lim = sy_var ? SPU_OVS_MID : (SPU_SYNC_FIXED_DIV >> 1) - 4'h1; // R8

  // transmit timing
  wire in_sync = (tx_st == SPU_TX_SYNC);
  wire t_tick = in_sync ? sy_src : tx_tick;
  wire t_end = t_tick & (tcnt == (in_sync ? sy_lim : SPU_OVS));
  wire [3:0] t_last = (mode1 ? SPU_FRAME_MODE1 : SPU_FRAME_MODE23) - 4'h1; // R10 R11
  wire sy_bit_end = in_sync & t_end & sy_ph;
  wire sy_last = sy_bit_end & (tbit == SPU_SYNC_BITS - 4'h1);
  wire tx_set = (tx_st == SPU_TX_ASYNC && t_end && tbit == t_last) | (sy_last & ~sy_rx);
  wire sy_rx_done = sy_last & sy_rx; // R7
  wire [7:0] sy_byte = {io_s, tsh[7:1]};
  wire sy_rx_go = wr_ctl & ~i_writedata[SPU_CTL_MODE_HI] & ~i_writedata[SPU_CTL_MODE_LO]
    & i_writedata[SPU_CTL_RX_EN] & ~i_writedata[SPU_CTL_RX_DONE]; // R6

  // receive timing
  wire rx_on = ctl[SPU_CTL_RX_EN] & ~mode0;
  wire fall = io_d & ~io_s; // R14
  wire [3:0] r_last = mode1 ? 4'h8 : 4'h9;
  wire r_samp = (rx_st == SPU_RX_BUSY) & rx_tick & (rcnt == SPU_OVS_MID); // R25
  wire false_start = r_samp & (rbit == 4'h0) & io_s;
  wire data_ev = r_samp & (rbit == r_last);
  wire stop_ev = r_samp & (rbit == r_last + 4'h1);
  wire [8:0] rsh_in = {io_s, rsh[8:1]}; // R2
  wire [8:0] rx_word = data_ev ? rsh_in : rsh;
  wire rx_ld = fce ? stop_ev : data_ev; // R17
  wire [7:0] rx_data = mode1 ? rx_word[8:1] : rx_word[7:0];
  wire rx9_ld = mode1 ? stop_ev : rx_ld;
  wire rx9_val = mode1 ? io_s : rx_word[8]; // R10 R11
  wire fe_set = stop_ev & fce & ~io_s; // R15

  // hardware sets win over a software write in the same cycle
  always_comb begin
    next_ctl = wr_ctl ? i_writedata[7:0] : ctl;
    if (tx_set) begin
      next_ctl[SPU_CTL_TX_DONE] = 1'b1; // R5
    end
    if (rx_ld | sy_rx_done) begin
      next_ctl[SPU_CTL_RX_DONE] = 1'b1; // R7
    end
    if (fe_set) begin
      next_ctl[SPU_CTL_FAULT] = 1'b1; // R16
    end
    if (rx9_ld) begin
      next_ctl[SPU_CTL_RX_NINTH] = rx9_val; // R10
    end
  end

  // bus slave: one wait cycle, answer in the cycle after
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
    end else begin
      o_waitrequest <= ~(req & o_waitrequest);
      if (req & o_waitrequest) begin
        o_readdata <= rd_mux;
      end
    end
  end

  // registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl <= SPU_CTL_RESET;
      rate_ctl <= SPU_RATE_RESET;
      pwr_ctl <= SPU_PWR_RESET;
      reload <= SPU_RELOAD_RESET;
      rx_buf <= SPU_BUF_RESET;
    end else begin
      ctl <= next_ctl; // R16
      if (wr_rate) rate_ctl <= i_writedata[7:0];
      if (wr_pwr) pwr_ctl <= i_writedata[7:0];
      if (wr_reload) reload <= i_writedata[7:0]; // R20
      if (sy_rx_done) begin
        rx_buf <= sy_byte; // R7
      end else if (rx_ld) begin
        rx_buf <= rx_data;
      end
    end
  end

  // input synchroniser and rate dividers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      io_m <= 1'b1;
      io_s <= 1'b1;
      io_d <= 1'b1;
      per_half <= 1'b0;
      h_per <= 1'b0;
      h_int <= 1'b0;
      h_t1 <= 1'b0;
    end else begin
      io_m <= i_io_in;
      io_s <= io_m;
      io_d <= io_s;
      per_half <= ~per_half; // R21
      if (per_tick) h_per <= ~h_per;
      if (ovf_int) h_int <= ~h_int;
      if (i_t1_ovf) h_t1 <= ~h_t1;
    end
  end

  spu_rate_gen u_rate_gen (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_per_tick(per_tick),
    .i_run(rate_ctl[SPU_RATE_RUN]),
    .i_bypass(rate_ctl[SPU_RATE_BYPASS]),
    .i_reload(reload),
    .o_ovf(ovf_int)
  );

  // transmitter and mode 0 shift engine
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_st <= SPU_TX_IDLE;
      tsh <= 10'h3ff;
      tbit <= 4'h0;
      tcnt <= 4'h0;
      sy_rx <= 1'b0;
      sy_ph <= 1'b0;
      o_out_pin <= 1'b1;
      o_io_out <= 1'b1;
      o_io_oe_n <= 1'b1;
    end else begin
      unique case (tx_st)
        SPU_TX_IDLE: begin
          tcnt <= 4'h0;
          tbit <= 4'h0;
          sy_ph <= 1'b0;
          o_out_pin <= 1'b1; // R24
          o_io_oe_n <= ~mode0;
          if (sy_rx_go) begin
            tx_st <= SPU_TX_SYNC; // R6
            sy_rx <= 1'b1;
            tsh <= 10'h3ff;
            o_io_oe_n <= 1'b1;
          end else if (wr_buf & mode0) begin
            tx_st <= SPU_TX_SYNC; // R3
            sy_rx <= 1'b0;
            tsh <= {2'b11, i_writedata[7:0]};
            o_io_out <= i_writedata[0]; // R3
            o_io_oe_n <= 1'b0;
          end else if (wr_buf) begin
            tx_st <= SPU_TX_ASYNC; // R13
            tsh <= {1'b1, mode1 | ctl[SPU_CTL_TX_NINTH], i_writedata[7:0]}; // R11
            o_out_pin <= 1'b0; // R24
          end
        end
        SPU_TX_ASYNC: begin
          if (t_tick) begin
            tcnt <= tcnt + 4'h1;
          end
          if (t_end) begin
            if (tbit == t_last) begin
              tx_st <= SPU_TX_IDLE;
            end else begin
              o_out_pin <= tsh[0]; // R11
              tsh <= {1'b1, tsh[9:1]};
              tbit <= tbit + 4'h1;
            end
          end
        end
        SPU_TX_SYNC: begin
          if (t_tick) begin
            tcnt <= t_end ? 4'h0 : tcnt + 4'h1;
          end
          if (t_end & ~sy_ph) begin
            sy_ph <= 1'b1;
            o_out_pin <= 1'b0; // R4
          end
          if (sy_bit_end) begin
            sy_ph <= 1'b0;
            o_out_pin <= 1'b1; // R4
            tsh <= {2'b11, sy_rx ? io_s : tsh[8], tsh[7:1]}; // R2
            o_io_out <= sy_rx ? o_io_out : (sy_last | tsh[1]); // R5
            tbit <= tbit + 4'h1; // R1
            if (sy_last) begin
              tx_st <= SPU_TX_IDLE;
            end
          end
        end
        default: tx_st <= SPU_TX_IDLE;
      endcase
    end
  end

  // asynchronous receiver
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rx_st <= SPU_RX_IDLE;
      rsh <= 9'h000;
      rbit <= 4'h0;
      rcnt <= 4'h0;
    end else begin
      unique case (rx_st)
        SPU_RX_IDLE: begin
          rcnt <= 4'h0;
          rbit <= 4'h0;
          if (rx_on & fall) begin
            rx_st <= SPU_RX_BUSY; // R14
          end
        end
        SPU_RX_BUSY: begin
          if (rx_tick) begin
            rcnt <= rcnt + 4'h1; // R25
          end
          if (r_samp && rbit != 4'h0 && rbit <= r_last) begin
            rsh <= rsh_in;
          end
          if (rx_tick && rcnt == SPU_OVS) begin
            rbit <= rbit + 4'h1;
          end
          if (~rx_on | false_start | stop_ev) begin
            rx_st <= SPU_RX_IDLE;
          end
        end
        default: rx_st <= SPU_RX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_rx_begin;
    rx_st == SPU_RX_IDLE ##1 rx_st == SPU_RX_BUSY;
  endsequence

  property p_fault_sticky;
    ctl[SPU_CTL_FAULT] && !wr_ctl |=> ctl[SPU_CTL_FAULT];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault lost"); // R16

  property p_fault_set;
    stop_ev && fce && !io_s |=> ctl[SPU_CTL_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("bad stop not flagged"); // R15

  property p_rx_late;
    data_ev && fce && !ctl[SPU_CTL_RX_DONE] && !wr_ctl |=> !ctl[SPU_CTL_RX_DONE];
  endproperty
  a_rx_late: assert property (p_rx_late) else $error("rx_done before stop bit"); // R17

  property p_idle_high;
    tx_st == SPU_TX_IDLE && !mode0 && !wr_buf |=> o_out_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high"); // R24

  property p_async_start;
    tx_st == SPU_TX_IDLE && wr_buf && !mode0 |=> !o_out_pin && tx_st == SPU_TX_ASYNC;
  endproperty
  a_async_start: assert property (p_async_start) else $error("no start bit"); // R13

  property p_sync_first;
    tx_st == SPU_TX_IDLE && wr_buf && mode0 && !sy_rx_go
      |=> o_io_out == $past(i_writedata[0]) && !o_io_oe_n && o_out_pin;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("d0 not on data pin"); // R3

  property p_sync_end;
    tx_set && in_sync |=> o_io_out && ctl[SPU_CTL_TX_DONE] && tx_st == SPU_TX_IDLE;
  endproperty
  a_sync_end: assert property (p_sync_end) else $error("mode 0 end wrong"); // R5

  property p_rx_begin;
    s_rx_begin |-> $past(io_d) && !$past(io_s) && $past(rx_on);
  endproperty
  a_rx_begin: assert property (p_rx_begin) else $error("frame began without edge"); // R14

  property p_pulse_shape;
    in_sync && !o_out_pin |-> sy_ph;
  endproperty
  a_pulse_shape: assert property (p_pulse_shape) else $error("clock low out of phase"); // R4

  property p_stop_ninth;
    stop_ev && mode1 |=> ctl[SPU_CTL_RX_NINTH] == $past(io_s);
  endproperty
  a_stop_ninth: assert property (p_stop_ninth) else $error("stop not in ninth bit"); // R10
endmodule : spu_serial_port

//--- spu_far_end.sv
// remote serial host and external shift register on the serial pins
`timescale 1ns/1ps
module spu_far_end (
  // clock
  input wire logic i_clock,
  // device pins
  input wire logic i_out_pin,
  input wire logic i_io_out,
  input wire logic i_io_oe_n,
  // resolved data line back to the device
  output logic o_io_in
);
  logic drv_en = 1'b0;
  logic drv_val = 1'b1;
  logic sh_run = 1'b0;
  logic pin_q = 1'b1;
  logic [7:0] sh_byte = 8'h00;
  // a released line floats to its pull-up; a driving device wins
  assign o_io_in = !i_io_oe_n ? i_io_out : (drv_en ? drv_val : 1'b1);
  // shift register presents its next bit after each rising shift clock
  always @(posedge i_clock) begin
    pin_q <= i_out_pin;
    if (sh_run && !pin_q && i_out_pin) begin
      sh_byte <= {1'b1, sh_byte[7:1]};
      drv_val <= sh_byte[1];
    end
  end
  task automatic shift_load(input logic [7:0] b);
    @(posedge i_clock);
    sh_byte <= b;
    drv_val <= b[0];
    drv_en <= 1'b1;
    sh_run <= 1'b1;
  endtask : shift_load
  task automatic shift_stop();
    @(posedge i_clock);
    sh_run <= 1'b0;
    drv_en <= 1'b0;
  endtask : shift_stop
  // frame is start, data lsb first, optional ninth, stop, as handed in
  task automatic send(input logic [10:0] bits, input int nb, input int per);
    for (int i = 0; i < nb; i++) begin
      @(posedge i_clock);
      drv_en <= 1'b1;
      drv_val <= bits[i];
      repeat (per - 1) @(posedge i_clock);
    end
    @(posedge i_clock);
    drv_en <= 1'b0;
  endtask : send
  task automatic grab(input int nb, input int per, output logic [10:0] bits);
    int n;
    bits = 11'h000;
    n = 0;
    while (i_out_pin !== 1'b0 && n < 4000) begin
      @(posedge i_clock);
      n++;
    end
    repeat (per / 2) @(posedge i_clock);
    for (int i = 0; i < nb; i++) begin
      bits[i] = i_out_pin;
      repeat (per) @(posedge i_clock);
    end
  endtask : grab
  // data is taken while the shift clock is low, where it is stable
  task automatic grab_sync(output logic [7:0] b, output int per, output int extra);
    int t;
    int last;
    int k;
    b = 8'h00;
    per = 0;
    extra = 0;
    last = 0;
    k = 0;
    for (t = 0; t < 3000 && k < 8; t++) begin
      @(posedge i_clock);
      if (pin_q && !i_out_pin) begin
        b[k] = i_io_out;
        per = t - last;
        last = t;
        k++;
      end
    end
    repeat (40) begin
      @(posedge i_clock);
      if (pin_q && !i_out_pin) extra++;
    end
  endtask : grab_sync
endmodule : spu_far_end

//--- tb_top.sv
// self-checking testbench for the serial port
`timescale 1ns/1ps
module tb_top;
  import spu_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic i_t1_ovf = 1'b0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_io_out;
  logic o_io_oe_n;
  logic o_out_pin;
  logic io_line;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [10:0] fr;
  logic [7:0] sb;
  int per;
  int extra;
  // async cases: mode 2 three settings at two rates, mode 1 generator, mode 3 split sources
  logic [7:0] t_ctl [5] = '{8'h98, 8'h90, 8'h98, 8'h50, 8'hd8};
  logic [7:0] t_rate [5] = '{8'h00, 8'h00, 8'h00, 8'h1e, 8'h1a};
  logic [7:0] t_rel [5] = '{8'h00, 8'h00, 8'h00, 8'hfe, 8'hff};
  logic [7:0] t_pwr [5] = '{8'h81, 8'h01, 8'h80, 8'h81, 8'h81};
  logic [7:0] t_tx [5] = '{8'ha5, 8'h5a, 8'h0f, 8'h96, 8'h33};
  logic [7:0] t_rx [5] = '{8'h3c, 8'hc3, 8'hf0, 8'h81, 8'he7};
  logic t_nine [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  int t_txp [5] = '{16, 32, 32, 32, 16};
  int t_rxp [5] = '{16, 32, 32, 32, 32};
  spu_serial_port u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_t1_ovf(i_t1_ovf), .i_io_in(io_line), .o_io_out(o_io_out),
    .o_io_oe_n(o_io_oe_n), .o_out_pin(o_out_pin)
  );
  spu_far_end u_far (
    .i_clock(i_clock), .i_out_pin(o_out_pin), .i_io_out(o_io_out),
    .i_io_oe_n(o_io_oe_n), .o_io_in(io_line)
  );
  initial begin
    forever #2 i_clock = ~i_clock;
  end
  // external timer overflows every second clock
  always @(posedge i_clock) i_t1_ovf <= !i_t1_ovf;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_write <= wr;
    i_read <= !wr;
    @(posedge i_clock);
    while (o_waitrequest !== 1'b0 && n < 50) begin
      @(posedge i_clock);
      n++;
    end
    if (n == 50) num_errors++;
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask : bus
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd_reg
  task automatic wait_ctl(input int b);
    int n;
    n = 0;
    rd_reg(SPU_ADDR_CONTROL);
    while (rd[b] !== 1'b1 && n < 400) begin
      rd_reg(SPU_ADDR_CONTROL);
      n++;
    end
  endtask : wait_ctl
  task automatic async_case(input int c);
    logic [10:0] ex;
    logic [10:0] rx;
    int nb;
    nb = t_ctl[c][7] ? 11 : 10;
    ex = t_ctl[c][7] ? {1'b1, t_ctl[c][3], t_tx[c], 1'b0} : {2'b01, t_tx[c], 1'b0};
    rx = t_ctl[c][7] ? {1'b1, t_nine[c], t_rx[c], 1'b0} : {2'b01, t_rx[c], 1'b0};
    wr_reg(SPU_ADDR_RATE, t_rate[c]);
    wr_reg(SPU_ADDR_RELOAD, t_rel[c]);
    wr_reg(SPU_ADDR_POWER, t_pwr[c]);
    wr_reg(SPU_ADDR_CONTROL, t_ctl[c]);
    // a generator that has just started counts up from its reset value before its first overflow
    repeat (300) @(posedge i_clock);
    fork
      wr_reg(SPU_ADDR_BUFFER, t_tx[c]);
      u_far.grab(nb, t_txp[c], fr);
    join
    chk("tx frame", 32'(fr), 32'(ex));
    chk("data released", 32'(o_io_oe_n), 32'h1);
    u_far.send(rx, nb, t_rxp[c]);
    rd_reg(SPU_ADDR_BUFFER);
    chk("rx byte", rd, 32'(t_rx[c]));
    rd_reg(SPU_ADDR_CONTROL);
    chk("control", rd, 32'(t_ctl[c] | 8'h03 | {t_nine[c], 2'b00}));
  endtask : async_case
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd_reg(5'(4 * i));
      chk("reset value", rd, 32'h0);
    end
    wr_reg(5'h14, 8'hff);
    rd_reg(5'h14);
    chk("unmapped", rd, 32'h0);
    wr_reg(SPU_ADDR_RELOAD, 8'hcc);
    rd_reg(SPU_ADDR_RELOAD);
    chk("reload", rd, 32'hcc);
    $display("test registers done");
    for (int c = 0; c < 5; c++) begin
      async_case(c);
    end
    $display("test async done");
    // fault stays through a later good frame; only a write clears it
    wr_reg(SPU_ADDR_POWER, 8'hc1);
    wr_reg(SPU_ADDR_CONTROL, 8'h90);
    for (int k = 0; k < 3; k++) begin
      u_far.send({k != 1, k != 1, 8'h3c ^ 8'(k), 1'b0}, 11, 16);
      rd_reg(SPU_ADDR_BUFFER);
      chk("fault byte", rd, 32'(8'h3c ^ 8'(k)));
      rd_reg(SPU_ADDR_CONTROL);
      chk("fault ctl", rd, k == 0 ? 32'h95 : k == 1 ? 32'hb1 : 32'hb5);
    end
    wr_reg(SPU_ADDR_CONTROL, 8'h90);
    rd_reg(SPU_ADDR_CONTROL);
    chk("fault clear", rd, 32'h90);
    $display("test framing done");
    wr_reg(SPU_ADDR_POWER, 8'h81);
    wr_reg(SPU_ADDR_RELOAD, 8'hff);
    for (int s = 0; s < 2; s++) begin
      wr_reg(SPU_ADDR_RATE, 8'h12 | 8'(s));
      wr_reg(SPU_ADDR_CONTROL, 8'h00);
      fork
        wr_reg(SPU_ADDR_BUFFER, 8'h96);
        u_far.grab_sync(sb, per, extra);
      join
      chk("sync byte", 32'(sb), 32'h96);
      chk("sync period", 32'(per), s ? 32'd16 : 32'd6);
      chk("extra pulses", 32'(extra), 32'h0);
      chk("data drive", 32'(o_io_oe_n), 32'h0);
      chk("data idle", 32'(o_io_out), 32'h1);
      wait_ctl(1);
      chk("sync tx done", 32'(rd[1]), 32'h1);
    end
    u_far.shift_load(8'h4b);
    wr_reg(SPU_ADDR_CONTROL, 8'h10);
    wait_ctl(0);
    u_far.shift_stop();
    rd_reg(SPU_ADDR_BUFFER);
    chk("sync rx", rd, 32'h4b);
    $display("test sync done");
    report_and_stop();
  end
endmodule : tb_top
